// File: hdl/rtcca_cfg.svh
// rtcca_cfg.svh : register offsets, field positions and reset values
// assumes inclusion by bare name from the capture/alarm register block
`ifndef RTCCA_CFG_SVH
`define RTCCA_CFG_SVH

// indirect byte register indices (byte address is four times the index)
`define RTCCA_IDX_SNAP0    8'h00
`define RTCCA_IDX_SNAP1    8'h01
`define RTCCA_IDX_SNAP2    8'h02
`define RTCCA_IDX_SNAP3    8'h03
`define RTCCA_IDX_ALARM_MATCH_BYTE0   8'h08
`define RTCCA_IDX_ALARM_MATCH_BYTE1   8'h09
`define RTCCA_IDX_ALARM_MATCH_BYTE2   8'h0A
`define RTCCA_IDX_ALARM_MATCH_BYTE3   8'h0B
// own control / interrupt registers
`define RTCCA_IDX_CTRL     8'h10
`define RTCCA_IDX_STATUS   8'h11
`define RTCCA_IDX_MASK     8'h12

// control register fields
`define RTCCA_CTRL_LOAD    0
`define RTCCA_CTRL_CAPT    1
`define RTCCA_CTRL_AEN     2
`define RTCCA_CTRL_RUN     3
// status / mask fields
`define RTCCA_ST_ALARM     0
`define RTCCA_ST_CAPT      1
`define RTCCA_ST_LOAD      2

// reset values
`define RTCCA_RST_BYTE     8'h00
`define RTCCA_RST_WORD     32'h0000_0000
`define RTCCA_RST_CTRL     8'h00
`define RTCCA_RST_IRQ      3'h0

// axi responses
`define RTCCA_RESP_OKAY    2'h0
`define RTCCA_RESP_SLVERR  2'h2

`endif

// File: hdl/rtcca_pkg.sv
// rtcca_pkg.sv : types shared by the capture/alarm register block
// assumes rtcca_cfg.svh holds the register and response constants; state encodings are here
package rtcca_pkg;
  // byte register lane within the snapshot or alarm word
  typedef logic [7:0]  rtcca_byte_t;
  typedef logic [31:0] rtcca_word_t;
  // write-channel handshake states, one-hot
  typedef enum logic [2:0] {
    RTCCA_W_IDLE = 3'b001,
    RTCCA_W_HAVE = 3'b010,
    RTCCA_W_RESP = 3'b100
  } rtcca_wstate_t;
endpackage

// File: hdl/rtcca_byte_word.sv
// rtcca_byte_word.sv : 32-bit word built of four byte-writable lanes
// assumes single clock, synchronous active-low reset, one writer
`timescale 1ns/1ns
module rtcca_byte_word #(
  parameter int WIDTH = 32
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] load_word,
  input  wire logic             load_en,
  input  wire logic [3:0]       lane_we,
  input  wire logic [7:0]       lane_data,
  output logic      [WIDTH-1:0] word_q
);
  logic [WIDTH-1:0] word_ff;     // stored word
  logic [WIDTH-1:0] nxt_word;    // next stored word

  assign word_q = word_ff;

  ////////////////////////////////////////////////////////////////////////////
  // lane writes; a whole-word load wins since hardware transfers are atomic
  always_comb begin
    nxt_word = word_ff;
    if (load_en) begin
      nxt_word = load_word;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (lane_we[i]) begin
          nxt_word[i*8 +: 8] = lane_data;   // lowest lane carries the lsb
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      word_ff <= '0;
    end else begin
      word_ff <= nxt_word;
    end
  end
endmodule

// File: hdl/rtcca_regs.sv
// rtcca_regs.sv : timer snapshot and alarm match registers over AXI4-Lite
// assumes one clock aclk, synchronous active-low reset, 32-bit AXI4-Lite
// Notes on behaviour
// - four snapshot bytes form 32-bit timer image
// - load moves image to timer; capture copies back
// - four alarm bytes hold 32-bit match value
// - alarm byte zero bit zero is lsb
`timescale 1ns/1ns
`include "rtcca_cfg.svh"
module rtcca_regs #(
  parameter int TICK_DIV = 1      // timer ticks every TICK_DIV clocks
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             alarm_pulse,
  output logic             irq
);
  import rtcca_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  rtcca_wstate_t    wst_ff, nxt_wst;        // write handshake state
  logic             aw_got_ff, nxt_aw_got;  // write address held
  logic             w_got_ff, nxt_w_got;    // write data held
  logic [7:0]       awaddr_ff, nxt_awaddr;
  logic [31:0]      wdata_ff, nxt_wdata;
  logic             wstrb0_ff, nxt_wstrb0;  // only lane 0 carries a byte reg
  logic [1:0]       bresp_ff, nxt_bresp;
  logic             rvalid_ff, nxt_rvalid;
  logic [31:0]      rdata_ff, nxt_rdata;
  logic [1:0]       rresp_ff, nxt_rresp;
  logic [3:0]       ctrl_ff, nxt_ctrl;      // load, capture, enable, run
  logic [2:0]       stat_ff, nxt_stat;      // sticky events
  logic [2:0]       mask_ff, nxt_mask;
  rtcca_word_t      timer_ff, nxt_timer;    // running timer
  logic [15:0]      div_ff, nxt_div;        // tick divider
  logic             alarm_ff, nxt_alarm;
  logic             match_ff, nxt_match;    // match seen last cycle
  rtcca_word_t      snap_q, alarm_q;
  logic [3:0]       snap_we, alarm_we;
  logic             wr_fire;                // a register write commits now
  logic [7:0]       widx;                   // word index of the write
  logic             tick;
  logic             do_load, do_capt;
  logic             match;

  // word index from a byte address; misaligned bits are ignored
  function automatic logic [7:0] idx_of(input logic [7:0] addr);
    idx_of = {2'b00, addr[7:2]};
  endfunction

  // true when an index names a mapped register
  function automatic logic mapped(input logic [7:0] idx);
    mapped = (idx <= `RTCCA_IDX_SNAP3) ||
             (idx >= `RTCCA_IDX_ALARM_MATCH_BYTE0 && idx <= `RTCCA_IDX_ALARM_MATCH_BYTE3) ||
             (idx >= `RTCCA_IDX_CTRL && idx <= `RTCCA_IDX_MASK);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order, then response
  assign s_axi_awready = wst_ff != RTCCA_W_RESP && !aw_got_ff;
  assign s_axi_wready  = wst_ff != RTCCA_W_RESP && !w_got_ff;
  assign s_axi_bvalid  = wst_ff == RTCCA_W_RESP;
  assign s_axi_bresp   = bresp_ff;
  assign widx          = idx_of(awaddr_ff);
  assign wr_fire       = wst_ff == RTCCA_W_HAVE && aw_got_ff && w_got_ff;

  always_comb begin
    nxt_wst    = wst_ff;
    nxt_aw_got = aw_got_ff;
    nxt_w_got  = w_got_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata  = wdata_ff;
    nxt_wstrb0 = wstrb0_ff;
    nxt_bresp  = bresp_ff;
    unique case (wst_ff)
      RTCCA_W_IDLE, RTCCA_W_HAVE: begin
        if (s_axi_awvalid && s_axi_awready) begin
          nxt_aw_got = 1'b1;
          nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          nxt_w_got  = 1'b1;
          nxt_wdata  = s_axi_wdata;
          nxt_wstrb0 = s_axi_wstrb[0];
        end
        if (wr_fire) begin
          // commit happens this cycle; answer next
          nxt_wst    = RTCCA_W_RESP;
          nxt_aw_got = 1'b0;
          nxt_w_got  = 1'b0;
          nxt_bresp  = mapped(widx) ? `RTCCA_RESP_OKAY : `RTCCA_RESP_SLVERR;
        end else if (nxt_aw_got || nxt_w_got) begin
          nxt_wst = RTCCA_W_HAVE;
        end
      end
      RTCCA_W_RESP: begin
        if (s_axi_bready) begin
          nxt_wst = RTCCA_W_IDLE;
        end
      end
      default: begin
        nxt_wst = RTCCA_W_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_ff    <= RTCCA_W_IDLE;
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff  <= 32'h0000_0000;
      wstrb0_ff <= 1'b0;
      bresp_ff  <= `RTCCA_RESP_OKAY;
    end else begin
      wst_ff    <= nxt_wst;
      aw_got_ff <= nxt_aw_got;
      w_got_ff  <= nxt_w_got;
      awaddr_ff <= nxt_awaddr;
      wdata_ff  <= nxt_wdata;
      wstrb0_ff <= nxt_wstrb0;
      bresp_ff  <= nxt_bresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte lane strobes into the snapshot and alarm words
  always_comb begin
    snap_we  = 4'h0;
    alarm_we = 4'h0;
    if (wr_fire && wstrb0_ff) begin
      for (int i = 0; i < 4; i++) begin
        if (widx == `RTCCA_IDX_SNAP0 + 8'(i)) begin
          snap_we[i] = 1'b1;
        end
        if (widx == `RTCCA_IDX_ALARM_MATCH_BYTE0 + 8'(i)) begin
          alarm_we[i] = 1'b1;
        end
      end
    end
  end

  // snapshot image: software bytes or a captured timer value
  rtcca_byte_word #(.WIDTH(32)) u_snap (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .load_word (timer_ff),
    .load_en   (do_capt),
    .lane_we   (snap_we),
    .lane_data (wdata_ff[7:0]),
    .word_q    (snap_q)
  );

  // alarm value, little-endian across the bytes
  rtcca_byte_word #(.WIDTH(32)) u_alarm (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .load_word (32'h0000_0000),
    .load_en   (1'b0),
    .lane_we   (alarm_we),
    .lane_data (wdata_ff[7:0]),
    .word_q    (alarm_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control: request bits self-clear once their transfer is done
  assign do_load = ctrl_ff[`RTCCA_CTRL_LOAD];
  assign do_capt = ctrl_ff[`RTCCA_CTRL_CAPT];

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_ctrl[`RTCCA_CTRL_LOAD] = 1'b0;
    nxt_ctrl[`RTCCA_CTRL_CAPT] = 1'b0;
    if (wr_fire && wstrb0_ff && widx == `RTCCA_IDX_CTRL) begin
      nxt_ctrl = wdata_ff[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer and alarm compare; the compare is not qualified by a write in
  // progress, so a half-written alarm can fire unless software disables it
  assign tick  = ctrl_ff[`RTCCA_CTRL_RUN] && div_ff == 16'(TICK_DIV - 1);
  assign match = ctrl_ff[`RTCCA_CTRL_AEN] && timer_ff == alarm_q;

  always_comb begin
    nxt_div   = div_ff;
    nxt_timer = timer_ff;
    if (ctrl_ff[`RTCCA_CTRL_RUN]) begin
      nxt_div = tick ? 16'h0000 : div_ff + 16'h0001;
    end
    if (do_load) begin
      nxt_timer = snap_q;
      nxt_div   = 16'h0000;
    end else if (tick) begin
      nxt_timer = timer_ff + 32'h0000_0001;
    end
    // one pulse on entry to the match, not every cycle it persists; a
    // stopped or divided timer holds the match for many cycles, so the
    // entry is found against last cycle's match, not against the pulse
    nxt_match = match;
    nxt_alarm = match && !match_ff;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff  <= 4'h0;
      div_ff   <= 16'h0000;
      timer_ff <= `RTCCA_RST_WORD;
      alarm_ff <= 1'b0;
      match_ff <= 1'b0;
    end else begin
      ctrl_ff  <= nxt_ctrl;
      div_ff   <= nxt_div;
      timer_ff <= nxt_timer;
      alarm_ff <= nxt_alarm;
      match_ff <= nxt_match;
    end
  end

  assign alarm_pulse = alarm_ff;

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky status, write-one-to-clear, set wins over clear
  always_comb begin
    nxt_mask = mask_ff;
    nxt_stat = stat_ff;
    if (wr_fire && wstrb0_ff && widx == `RTCCA_IDX_STATUS) begin
      nxt_stat = stat_ff & ~wdata_ff[2:0];
    end
    if (wr_fire && wstrb0_ff && widx == `RTCCA_IDX_MASK) begin
      nxt_mask = wdata_ff[2:0];
    end
    if (nxt_alarm && !alarm_ff) begin
      nxt_stat[`RTCCA_ST_ALARM] = 1'b1;
    end
    if (do_capt) begin
      nxt_stat[`RTCCA_ST_CAPT] = 1'b1;
    end
    if (do_load) begin
      nxt_stat[`RTCCA_ST_LOAD] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_ff <= `RTCCA_RST_IRQ;
      mask_ff <= `RTCCA_RST_IRQ;
    end else begin
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
    end
  end

  assign irq = |(stat_ff & mask_ff);

  ////////////////////////////////////////////////////////////////////////////
  // read channel: data one cycle after the address is taken
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  always_comb begin
    logic [7:0] ridx;
    ridx       = idx_of(s_axi_araddr);
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = mapped(ridx) ? `RTCCA_RESP_OKAY : `RTCCA_RESP_SLVERR;
      nxt_rdata  = 32'h0000_0000;
      if (ridx <= `RTCCA_IDX_SNAP3) begin
        nxt_rdata[7:0] = snap_q[ridx[1:0]*8 +: 8];
      end else if (ridx >= `RTCCA_IDX_ALARM_MATCH_BYTE0 && ridx <= `RTCCA_IDX_ALARM_MATCH_BYTE3) begin
        nxt_rdata[7:0] = alarm_q[ridx[1:0]*8 +: 8];
      end else if (ridx == `RTCCA_IDX_CTRL) begin
        nxt_rdata[3:0] = ctrl_ff;
      end else if (ridx == `RTCCA_IDX_STATUS) begin
        nxt_rdata[2:0] = stat_ff;
      end else if (ridx == `RTCCA_IDX_MASK) begin
        nxt_rdata[2:0] = mask_ff;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= `RTCCA_RESP_OKAY;
    end else begin
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
    end
  end
endmodule

// File: verification/rtcca_regs_assertions.sv
// rtcca_regs_assertions.sv : port checker for the snapshot/alarm registers
// assumes it is bound onto rtcca_regs, one clock, sync active-low reset
`timescale 1ns/1ns
`include "rtcca_cfg.svh"
module rtcca_chk #(
  parameter int TICK_DIV = 1
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        alarm_pulse,
  input wire logic        irq
);
  // single domain, so clock and reset are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  //////////////////////////////////////////////////////////////////////////////
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  a_write_gate: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_gate: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read ready wrong");
  a_upper_zero: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h000000) else $error("upper read bits set");
  a_alarm_once: assert property (alarm_pulse |=> !alarm_pulse)
    else $error("alarm pulse too long");
  // main scenarios reached
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_alarm: cover property (alarm_pulse);
  c_irq: cover property (irq);
endmodule
bind rtcca_regs rtcca_chk #(.TICK_DIV(TICK_DIV)) u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .alarm_pulse(alarm_pulse), .irq(irq));

// File: verification/rtc_capture_alarm_regs_tb_top.sv
// rtc_capture_alarm_regs_tb_top.sv : self-checking bench for rtcca_regs
// assumes TICK_DIV 1, so the timer steps once per clock while running
`timescale 1ns/1ns
`include "rtcca_cfg.svh"
module rtc_capture_alarm_regs_tb_top;
  import rtcca_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0;       // clock and sync reset
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;    // byte addresses
  logic [31:0] wdata = 32'h0, rdata, seed = 32'h1DBC;
  logic [3:0]  wstrb = 4'hF;                      // byte lane 0 must be on
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic        rready = 1'b0, awready, wready, bvalid, arready, rvalid, alarm_pulse, irq;
  logic [1:0]  bresp, rresp;
  int          mismatches = 0, checks = 0;
  rtcca_regs #(.TICK_DIV(1)) uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .alarm_pulse(alarm_pulse), .irq(irq));
  // 40 ns period
  initial begin
    forever #20 aclk = ~aclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  // xorshift source, fixed seed so runs repeat
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // byte k of a word as one register reads it back, lsb byte first
  function automatic logic [31:0] lane(input logic [31:0] w, input int k);
    return {24'h000000, w[8*k +: 8]};
  endfunction
  // register index of byte i: snapshot 0..3 then alarm 0..3
  function automatic logic [7:0] idx_of(input int i);
    return (i < 4) ? 8'(i) : 8'(i + 4);
  endfunction
  task automatic results;
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // counted compare; an unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one bounded bus step; a spent budget ends the run
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 200) begin
      mismatches++;
      $display("BAD %0t bus hang", $time);
      results();
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // address and data offered together, each dropped once taken
  task automatic wrchk(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= {idx[5:0], 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      tick(n);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    chk(bresp, er, "bresp");
    bready <= 1'b0;
  endtask
  // read one register; rready held until the answer is seen
  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= {idx[5:0], 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      tick(n);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    rd(idx, d, r);
    chk(d, ed, "rdata");
    chk(r, er, "rresp");
  endtask
  // irq is decoded from the registered status and mask, so give it two edges to settle
  task automatic irqchk(input logic e);
    repeat (2) @(posedge aclk);
    chk(irq, e, "irq");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d, s, a, c;
    logic [1:0]  r;
    int          n;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++) rdchk(idx_of(i), 32'h0, `RTCCA_RESP_OKAY);
    // random bytes with junk in the upper bits, which must read 0
    for (int k = 0; k < 24; k++) begin
      seed = xs(seed);
      wrchk(idx_of(k % 8), seed, `RTCCA_RESP_OKAY);
      rdchk(idx_of(k % 8), lane(seed, 0), `RTCCA_RESP_OKAY);
    end
    wrchk(8'h05, 32'hA5, `RTCCA_RESP_SLVERR);
    rdchk(8'h05, 32'h0, `RTCCA_RESP_SLVERR);
    // lane 0 strobe off: the write is answered but changes nothing
    wrchk(8'h00, 32'h3C, `RTCCA_RESP_OKAY);
    wstrb <= 4'hE;
    wrchk(8'h00, 32'hC3, `RTCCA_RESP_OKAY);
    wstrb <= 4'hF;
    rdchk(8'h00, 32'h3C, `RTCCA_RESP_OKAY);
    // alarm off before the match bytes change
    wrchk(`RTCCA_IDX_CTRL, 32'h0, `RTCCA_RESP_OKAY);
    seed = xs(seed);
    s = {seed[31:8], 8'hF0};
    a = s + 32'h0000_0028;                          // carries into byte 1
    for (int i = 0; i < 4; i++) begin
      wrchk(idx_of(i), lane(s, i), `RTCCA_RESP_OKAY);
      wrchk(idx_of(i + 4), lane(a, i), `RTCCA_RESP_OKAY);
    end
    wrchk(`RTCCA_IDX_MASK, 32'h1, `RTCCA_RESP_OKAY);
    wrchk(`RTCCA_IDX_CTRL, 32'h1 << `RTCCA_CTRL_LOAD, `RTCCA_RESP_OKAY);
    irqchk(1'b0);
    wrchk(`RTCCA_IDX_CTRL, (32'h1 << `RTCCA_CTRL_AEN) | (32'h1 << `RTCCA_CTRL_RUN),
      `RTCCA_RESP_OKAY);
    n = 0;
    while (!alarm_pulse && n < 100) begin
      @(posedge aclk);
      n++;
    end
    chk(n > 30 && n < 45, 1, "alarm time");
    irqchk(1'b1);
    wrchk(`RTCCA_IDX_CTRL, (32'h1 << `RTCCA_CTRL_AEN) | (32'h1 << `RTCCA_CTRL_RUN) |
      (32'h1 << `RTCCA_CTRL_CAPT), `RTCCA_RESP_OKAY);
    c = 32'h0;
    for (int i = 0; i < 4; i++) begin
      rd(idx_of(i), d, r);
      c = c | ({24'h000000, d[7:0]} << (8 * i));
    end
    chk(c > a && c < a + 32'h0000_0014, 1, "captured time");
    rd(`RTCCA_IDX_STATUS, d, r);
    chk(d[`RTCCA_ST_ALARM], 1, "alarm status");
    wrchk(`RTCCA_IDX_STATUS, 32'h1, `RTCCA_RESP_OKAY);
    irqchk(1'b0);
    wrchk(`RTCCA_IDX_MASK, 32'h1 << `RTCCA_ST_CAPT, `RTCCA_RESP_OKAY);
    irqchk(1'b1);
    wrchk(`RTCCA_IDX_MASK, 32'h0, `RTCCA_RESP_OKAY);
    irqchk(1'b0);
    // stopped timer parked on the alarm value: one pulse, then silence
    wrchk(`RTCCA_IDX_CTRL, 32'h0, `RTCCA_RESP_OKAY);
    for (int i = 0; i < 4; i++) wrchk(idx_of(i), lane(a, i), `RTCCA_RESP_OKAY);
    wrchk(`RTCCA_IDX_CTRL, (32'h1 << `RTCCA_CTRL_LOAD) | (32'h1 << `RTCCA_CTRL_AEN),
      `RTCCA_RESP_OKAY);
    n = 0;
    repeat (20) begin
      @(posedge aclk);
      n += alarm_pulse;
    end
    chk(n, 1, "alarm repeats");
    results();
  end
endmodule
